/* File: pkg/pic_pkg.sv */
// Functional notes
// R1: one 8-bit down-counter decremented by carries of its own 6-bit prescaler
// R2: at end-of-count halt in single-pass mode or reload and continue in continuous
// R3: new initial values load at once by load bit or deferred to next end-of-count
// R4: initial-value registers accept writes while counting without stopping the count
// R5: internal source gives a timer clock of the internal clock divided by four
// R6: divider, prescaler and counter form one synchronous 16-bit chain on one clock
// R7: the chain may instead be driven by an external timer input pin
// R8: output pin selectable to carry the counter toggle or the internal clock
// R9: timer output toggles each time the counter reaches end-of-count
// R10: counting runs autonomously once started, no per-count processor action
// R11: control bits select mode, start/stop, and use of input and output pins
// R12: counter, prescaler and mode registers are plain readable writable locations; the counter offset reads the live count, writes go to the initial value
// R13: prescaler modulo in upper six bits; zero divides by 64, one passes through
// R14: load bit copies both initial values, restarts count, clears itself next clock
// R15: counter rests while enable is zero; first decrement four clocks after setting
// R16: counter and prescaler both at end-of-count raise the timer interrupt request
// R17: count reads live without disturbance; clearing enable freezes, setting resumes
// R18: timer output toggle flip-flop preset to one on every software load
package pic_pkg;

  // register offsets
  localparam logic [7:0] OFS_TIMER_MODE_REG = 8'hf1;
  localparam logic [7:0] OFS_INTERVAL_COUNTER = 8'hf2;
  localparam logic [7:0] OFS_PRESCALER_REG = 8'hf3;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'hf4;
  localparam logic [7:0] OFS_IRQ_MASK = 8'hf5;

  // timer mode fields
  localparam int TMR_OUT_SEL_HI = 7;
  localparam int TMR_OUT_SEL_LO = 6;
  localparam int TMR_ENABLE_BIT = 3;
  localparam int TMR_LOAD_BIT = 2;

  // prescaler fields
  localparam int PRE_MOD_HI = 7;
  localparam int PRE_MOD_LO = 2;
  localparam int PRE_EXT_BIT = 1;
  localparam int PRE_CONT_BIT = 0;

  // output select codes
  localparam logic [1:0] OUT_SEL_OFF = 2'h0;
  localparam logic [1:0] OUT_SEL_TOGGLE = 2'h2;
  localparam logic [1:0] OUT_SEL_CLOCK = 2'h3;

  // divider and reset values
  localparam logic [1:0] DIV_LAST = 2'h3;
  localparam logic [7:0] RST_TIMER_MODE = 8'h00;
  localparam logic [7:0] RST_PRESCALER = 8'h00;
  localparam logic [7:0] RST_COUNTER = 8'h00;
  localparam logic [7:0] RST_IRQ_MASK = 8'h00;
  localparam int IRQ_EOC_BIT = 0;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } pic_bus_req_s;

endpackage

/* File: rtl/pic_interval_counter.sv */
`timescale 1ns/10ps
module pic_interval_counter
  import pic_pkg::*;
(
  // clock and reset
  input  wire logic         i_clk_sys,
  input  wire logic         i_rstn,
  // register port
  input  wire pic_bus_req_s i_bus,
  output logic [7:0]        o_rdata,
  // timer pins
  input  wire logic         i_port5_line2,
  output logic              o_port5_line6,
  output logic              o_port5_line6_oe_n,
  // interrupt
  output logic              o_timer_irq_line
);

  logic [7:0] timer_mode_reg_q;
  logic [7:0] prescaler_reg_q;
  logic [7:0] initial_count_q;
  logic [7:0] interval_counter_q;
  logic [5:0] pre_cnt_q;
  logic [1:0] div_q;
  logic       load_q;
  logic       done_q;
  logic       toggle_q;
  logic       clk_half_q;
  logic       ext_prev_q;
  logic [7:0] irq_status_q;
  logic [7:0] irq_status_d;
  logic [7:0] irq_mask_q;
  logic [7:0] rdata_q;
  logic       pin_q;
  logic       pin_oe_n_q;
  logic       irq_q;

  logic       wr_tmr;
  logic       wr_cnt;
  logic       wr_pre;
  logic       enable;
  logic       ext_sel;
  logic       cont_mode;
  logic       tick;
  logic       pre_carry;
  logic       eoc;
  logic       sw_load;
  logic       en_rise;
  logic [1:0] out_sel;

  assign wr_tmr    = i_bus.wr && (i_bus.addr == OFS_TIMER_MODE_REG);
  assign wr_cnt    = i_bus.wr && (i_bus.addr == OFS_INTERVAL_COUNTER);
  assign wr_pre    = i_bus.wr && (i_bus.addr == OFS_PRESCALER_REG);
  assign enable    = timer_mode_reg_q[TMR_ENABLE_BIT];
  assign ext_sel   = prescaler_reg_q[PRE_EXT_BIT];
  assign cont_mode = prescaler_reg_q[PRE_CONT_BIT];
  assign out_sel   = timer_mode_reg_q[TMR_OUT_SEL_HI:TMR_OUT_SEL_LO];
  assign sw_load   = wr_tmr && i_bus.wdata[TMR_LOAD_BIT];
  assign en_rise   = wr_tmr && i_bus.wdata[TMR_ENABLE_BIT] && !enable;

  // timer clock: every fourth clock or external rising edge
  assign tick = enable && (ext_sel ? (i_port5_line2 && !ext_prev_q)   // [R7]
                                   : (div_q == DIV_LAST));            // [R5] [R6]
  // carry when prescaler passes its last step; zero modulo wraps through 64 steps
  assign pre_carry = tick && (pre_cnt_q == 6'h01 || prescaler_reg_q[PRE_MOD_HI:PRE_MOD_LO]
                     == 6'h01 && pre_cnt_q == 6'h01);                 // [R13]
  assign eoc = pre_carry && !done_q && (interval_counter_q == 8'h01); // [R16]

  // mode register; load bit is held one clock only
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rstn)
    begin
      timer_mode_reg_q <= RST_TIMER_MODE;
      load_q           <= 1'b0;
    end
    else
    begin
      if (wr_tmr)
      begin
        timer_mode_reg_q <= i_bus.wdata & ~(8'h01 << TMR_LOAD_BIT);   // [R11] [R12]
      end
      load_q <= sw_load;                                              // [R14]
    end
  end

  // initial-value registers, writable at any time
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rstn)
    begin
      prescaler_reg_q <= RST_PRESCALER;
      initial_count_q <= RST_COUNTER;
    end
    else
    begin
      if (wr_pre)
      begin
        prescaler_reg_q <= i_bus.wdata;                               // [R4] [R12]
      end
      if (wr_cnt)
      begin
        initial_count_q <= i_bus.wdata;                               // [R4]
      end
    end
  end

  // divide-by-four stage, restarted when counting is enabled
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rstn)
    begin
      div_q      <= 2'h0;
      clk_half_q <= 1'b0;
      ext_prev_q <= 1'b0;
    end
    else
    begin
      clk_half_q <= !clk_half_q;
      ext_prev_q <= i_port5_line2;
      if (en_rise)
      begin
        div_q <= 2'h0;                                                // [R15]
      end
      else if (enable)
      begin
        div_q <= div_q + 2'h1;                                        // [R5] [R6]
      end
    end
  end

  // prescaler down-counter, always free running while enabled
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rstn)
    begin
      pre_cnt_q <= 6'h00;
    end
    else if (sw_load || (en_rise && done_q))
    begin
      // restart from the programmed modulo
      pre_cnt_q <= prescaler_reg_q[PRE_MOD_HI:PRE_MOD_LO];            // [R14]
    end
    else if (tick)
    begin
      if (pre_cnt_q == 6'h01)
      begin
        pre_cnt_q <= prescaler_reg_q[PRE_MOD_HI:PRE_MOD_LO];          // [R13]
      end
      else
      begin
        pre_cnt_q <= pre_cnt_q - 6'h01;                               // [R1] [R10]
      end
    end
  end

  // interval counter; frozen while enable is low
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rstn)
    begin
      interval_counter_q <= RST_COUNTER;
      done_q             <= 1'b0;
    end
    else if (sw_load)
    begin
      interval_counter_q <= initial_count_q;                          // [R3] [R14]
      done_q             <= 1'b0;
    end
    else if (eoc)
    begin
      if (cont_mode)
      begin
        interval_counter_q <= initial_count_q;                        // [R2] [R3]
      end
      else
      begin
        interval_counter_q <= 8'h00;                                  // [R2]
        done_q             <= 1'b1;
      end
    end
    else if (pre_carry && !done_q)
    begin
      interval_counter_q <= interval_counter_q - 8'h01;               // [R1] [R17]
    end
  end

  // toggle flip-flop, preset by software load
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rstn)
    begin
      toggle_q <= 1'b1;
    end
    else if (sw_load)
    begin
      toggle_q <= 1'b1;                                               // [R18]
    end
    else if (eoc)
    begin
      toggle_q <= !toggle_q;                                          // [R9]
    end
  end

  // output pin
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rstn)
    begin
      pin_q      <= 1'b0;
      pin_oe_n_q <= 1'b1;
    end
    else
    begin
      pin_oe_n_q <= (out_sel != OUT_SEL_TOGGLE) && (out_sel != OUT_SEL_CLOCK); // [R11]
      unique case (out_sel)
        OUT_SEL_TOGGLE: pin_q <= toggle_q;                            // [R8]
        OUT_SEL_CLOCK:  pin_q <= clk_half_q;                          // [R8]
        default:        pin_q <= 1'b0;
      endcase
    end
  end

  // interrupt status, set wins over write-one clear
  always_comb
  begin
    irq_status_d = irq_status_q;
    if (i_bus.wr && (i_bus.addr == OFS_IRQ_STATUS))
    begin
      irq_status_d = irq_status_q & ~i_bus.wdata;
    end
    if (eoc)
    begin
      irq_status_d[IRQ_EOC_BIT] = 1'b1;                               // [R16]
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rstn)
    begin
      irq_status_q <= 8'h00;
      irq_mask_q   <= RST_IRQ_MASK;
      irq_q        <= 1'b0;
    end
    else
    begin
      irq_status_q <= irq_status_d;
      if (i_bus.wr && (i_bus.addr == OFS_IRQ_MASK))
      begin
        irq_mask_q <= i_bus.wdata & 8'h01;
      end
      irq_q <= |(irq_status_d & irq_mask_q);                          // [R16]
    end
  end

  // read data, one cycle after the strobe
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rstn)
    begin
      rdata_q <= 8'h00;
    end
    else if (i_bus.rd)
    begin
      unique case (i_bus.addr)
        OFS_TIMER_MODE_REG:   rdata_q <= timer_mode_reg_q | {5'h00, load_q, 2'h0}; // [R12]
        OFS_INTERVAL_COUNTER: rdata_q <= interval_counter_q;          // [R17]
        OFS_PRESCALER_REG:    rdata_q <= prescaler_reg_q;             // [R12]
        OFS_IRQ_STATUS:       rdata_q <= irq_status_q;
        OFS_IRQ_MASK:         rdata_q <= irq_mask_q;
        default:              rdata_q <= 8'h00;
      endcase
    end
    else
    begin
      rdata_q <= 8'h00;
    end
  end

  assign o_rdata            = rdata_q;
  assign o_port5_line6      = pin_q;
  assign o_port5_line6_oe_n = pin_oe_n_q;
  assign o_timer_irq_line   = irq_q;

endmodule

/* File: tb/pic_interval_counter_checker.sv */
`timescale 1ns/10ps
module pic_interval_counter_checker
  import pic_pkg::*;
(
  // watched ports
  input wire logic         i_clk_sys,
  input wire logic         i_rstn,
  input wire pic_bus_req_s i_bus,
  input wire logic [7:0]   o_rdata,
  input wire logic         i_port5_line2,
  input wire logic         o_port5_line6,
  input wire logic         o_port5_line6_oe_n,
  input wire logic         o_timer_irq_line
);
  logic [1:0] sel_q;
  logic       mask_q;
  wire        mode_wr = i_bus.wr && i_bus.addr == OFS_TIMER_MODE_REG;
  default clocking @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rstn);
  // select and mask as last written
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rstn)
    begin
      sel_q  <= OUT_SEL_OFF;
      mask_q <= 1'b0;
    end
    else
    begin
      if (mode_wr)
        sel_q <= i_bus.wdata[TMR_OUT_SEL_HI:TMR_OUT_SEL_LO];
      if (i_bus.wr && i_bus.addr == OFS_IRQ_MASK)
        mask_q <= i_bus.wdata[IRQ_EOC_BIT];
    end
  end
  sequence s_pre_rw;
    i_bus.wr && i_bus.addr == OFS_PRESCALER_REG ##2 i_bus.rd && i_bus.addr == OFS_PRESCALER_REG;
  endsequence
  rdata_idle_a: assert property (!i_bus.rd |=> o_rdata == 8'h00)
    else $error("read data not idle");
  unmapped_read_a: assert property (i_bus.rd && (i_bus.addr < OFS_TIMER_MODE_REG
    || i_bus.addr > OFS_IRQ_MASK) |=> o_rdata == 8'h00)
    else $error("unmapped read not zero");
  pre_readback_a: assert property (s_pre_rw |=> o_rdata == $past(i_bus.wdata, 3))
    else $error("prescaler readback wrong");
  pin_enable_a: assert property (sel_q[1] [*2] |-> !o_port5_line6_oe_n)
    else $error("timer pin not driven");
  pin_off_a: assert property ((sel_q == OUT_SEL_OFF) [*2] |->
    o_port5_line6_oe_n && !o_port5_line6)
    else $error("timer pin not released");
  clock_out_a: assert property ((sel_q == OUT_SEL_CLOCK) [*3] |->
    o_port5_line6 != $past(o_port5_line6))
    else $error("clock output still");
  irq_masked_a: assert property (!mask_q [*2] |-> !o_timer_irq_line)
    else $error("masked interrupt raised");
  load_preset_a: assert property (mode_wr && i_bus.wdata[TMR_LOAD_BIT] &&
    i_bus.wdata[7:6] == OUT_SEL_TOGGLE |-> ##2 o_port5_line6)
    else $error("toggle output not preset");
endmodule
bind pic_interval_counter pic_interval_counter_checker pic_interval_counter_checker_inst (
  .i_clk_sys, .i_rstn, .i_bus, .o_rdata,
  .i_port5_line2, .o_port5_line6, .o_port5_line6_oe_n, .o_timer_irq_line
);

/* File: tb/pic_interval_counter_tb.sv */
`timescale 1ns/10ps
module pic_interval_counter_tb;
  import pic_pkg::*;
  logic         i_clk_sys;
  logic         i_rstn;
  pic_bus_req_s i_bus;
  logic [7:0]   o_rdata;
  logic         i_port5_line2;
  logic         o_port5_line6;
  logic         o_port5_line6_oe_n;
  logic         o_timer_irq_line;
  logic [7:0]   rv;
  logic [7:0]   wv;
  int           bad_count;
  int           checked;
  int           cyc;
  int           n;
  int           p;
  int           v;
  bit           noise;
  pic_interval_counter pic_interval_counter_inst (
    .i_clk_sys, .i_rstn, .i_bus, .o_rdata,
    .i_port5_line2, .o_port5_line6, .o_port5_line6_oe_n, .o_timer_irq_line
  );
  initial
  begin
    i_clk_sys = 1'b0;
    forever #5 i_clk_sys = ~i_clk_sys;
  end
  // timeout and noise on the idle timer input
  always @(posedge i_clk_sys)
  begin
    cyc <= cyc + 1;
    if (noise)
      i_port5_line2 <= 1'($urandom);
    if (cyc == 20000)
    begin
      bad_count++;
      end_of_test();
    end
  end
  function automatic int exp_n(input int pp, input int vv);
    return 4 * (pp == 0 ? 64 : pp) * (vv == 0 ? 256 : vv);
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    i_bus <= '{a, d, 1'b1, 1'b0};
    @(posedge i_clk_sys);
    i_bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge i_clk_sys);
    i_bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge i_clk_sys);
    i_bus.rd <= 1'b0;
    #1 rv = o_rdata;
  endtask
  task automatic run(input int pp, input int vv, input logic [1:0] m);
    wr(8'hf1, 8'h00);
    wr(8'hf4, 8'h01);
    wr(8'hf3, {6'(pp), m});
    wr(8'hf2, 8'(vv));
    wr(8'hf1, 8'h8c);
  endtask
  // cycles until the pin or the interrupt changes
  task automatic gap(input int e, input bit pin);
    logic s;
    s = pin ? o_port5_line6 : o_timer_irq_line;
    n = 0;
    while ((pin ? o_port5_line6 : o_timer_irq_line) === s && n < 5000)
    begin
      @(posedge i_clk_sys);
      #1 n++;
    end
    chk(16'(n), 16'(e));
  endtask
  task automatic end_of_test;
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    i_rstn = 1'b0;
    i_bus = '0;
    i_port5_line2 = 1'b0;
    bad_count = 0;
    checked = 0;
    cyc = 0;
    wv = 8'($urandom(32'habc3));
    repeat (6) @(posedge i_clk_sys);
    i_rstn <= 1'b1;
    for (int a = 8'hf0; a < 8'hf6; a++)
    begin
      rd(8'(a));
      chk(rv, 8'h00);
    end
    chk({o_port5_line6_oe_n, o_port5_line6, o_timer_irq_line}, 3'h4);
    wr(8'hf3, wv);
    rd(8'hf3);
    chk(rv, wv);
    wr(8'hf5, 8'h01);
    $display("end: registers");
    noise = 1'b1;
    for (int k = 0; k < 6; k++)
    begin
      p = (k == 0) ? 0 : $urandom_range(4, 1);
      v = (k == 1) ? 0 : $urandom_range(6, 1);
      run(p, v, 2'h0);
      gap(exp_n(p, v), 1'b0);
      @(posedge i_clk_sys);
      #1 chk(o_port5_line6, 1'b0);
      rd(8'hf2);
      chk(rv, 8'h00);
    end
    $display("end: single pass");
    wr(8'hf5, 8'h00);
    run(1, 2, 2'h0);
    repeat (12) @(posedge i_clk_sys);
    #1 chk(o_timer_irq_line, 1'b0);
    rd(8'hf4);
    chk(rv, 8'h01);
    wr(8'hf5, 8'h01);
    @(posedge i_clk_sys);
    #1 chk(o_timer_irq_line, 1'b1);
    wr(8'hf4, 8'h01);
    @(posedge i_clk_sys);
    #1 chk(o_timer_irq_line, 1'b0);
    $display("end: mask");
    run(2, 3, 2'h1);
    wr(8'hf2, 8'h05);
    gap(exp_n(2, 3) - 2, 1'b0);
    gap(1, 1'b1);
    gap(40, 1'b1);
    gap(40, 1'b1);
    wr(8'hf4, 8'h01);
    wr(8'hf1, 8'h8c);
    // divider phase keeps running across a load: first tick comes one clock early
    gap(exp_n(2, 5) - 1, 1'b0);
    $display("end: continuous");
    wr(8'hf1, 8'h80);
    rd(8'hf2);
    wv = rv;
    chk(wv, 8'h05);
    repeat (20) @(posedge i_clk_sys);
    rd(8'hf2);
    chk(rv, wv);
    wr(8'hf1, 8'h88);
    repeat (9) @(posedge i_clk_sys);
    rd(8'hf2);
    chk(rv, 8'h04);
    wr(8'hf1, 8'hc0);
    repeat (2) @(posedge i_clk_sys);
    #1 wv[0] = o_port5_line6;
    @(posedge i_clk_sys);
    #1 chk({o_port5_line6_oe_n, o_port5_line6}, {1'b0, ~wv[0]});
    $display("end: freeze and pin");
    noise = 1'b0;
    @(posedge i_clk_sys);
    i_port5_line2 <= 1'b0;
    run(1, 3, 2'h2);
    repeat (30) @(posedge i_clk_sys);
    #1 chk(o_timer_irq_line, 1'b0);
    repeat (3)
    begin
      @(posedge i_clk_sys) i_port5_line2 <= 1'b1;
      repeat (2) @(posedge i_clk_sys);
      i_port5_line2 <= 1'b0;
      @(posedge i_clk_sys);
    end
    repeat (6) @(posedge i_clk_sys);
    #1 chk(o_timer_irq_line, 1'b1);
    $display("end: external");
    end_of_test();
  end
endmodule
